// file: serial_flash_erase_sleep_id_tb.sv
// Testbench for the erase, sleep and identification block
`timescale 1ns/1ps
`default_nettype none
`include "sfesi_cfg.svh"
module serial_flash_erase_sleep_id_tb;
  import sfesi_pkg::*;
  // Short erase for simulation
  localparam int ERASE_CYC = 20;
  logic sys_clk;
  logic rst;
  sfesi_spi_s spi;
  logic serial_out, serial_out_en_n, ext_busy, write_latch_flag, busy, latch_clear, asleep;
  logic [2:0] protect_range_bits;
  logic wren;
  logic [`SFESI_ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data, rx;
  int n_errors, total_checks, n_clear;
  // Device under test
  sfesi_core #(.ERASE_CYC(ERASE_CYC)) u_sfesi_core (.sys_clk(sys_clk), .rst(rst), .spi(spi),
    .serial_out(serial_out), .serial_out_en_n(serial_out_en_n), .ext_busy(ext_busy),
    .write_latch_flag(write_latch_flag), .protect_range_bits(protect_range_bits), .busy(busy),
    .latch_clear(latch_clear), .asleep(asleep), .rd_addr(rd_addr), .rd_data(rd_data));
  // Host side
  sfesi_host u_sfesi_host (.sys_clk(sys_clk), .spi(spi), .serial_out(serial_out),
    .serial_out_en_n(serial_out_en_n));
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Count latch clear pulses
  always @(posedge sys_clk) begin
    if (latch_clear === 1'b1) begin
      n_clear++;
    end
  end
  // Status latch: set by write enable, cleared by the device
  always @(posedge sys_clk) begin
    if (rst || latch_clear === 1'b1) begin
      write_latch_flag <= 1'b0;
    end else if (wren) begin
      write_latch_flag <= 1'b1;
    end
  end
  // Host write enable, one cycle
  task automatic set_wel();
    wren = 1'b1;
    u_sfesi_host.wait_n(1);
    wren = 1'b0;
    u_sfesi_host.wait_n(1);
  endtask
  // Compare one value
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Verdict and stop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One opcode frame of nb bits
  task automatic op_frame(input logic [7:0] op, input int nb);
    u_sfesi_host.frame_open();
    u_sfesi_host.xfer(op, 8, rx);
    if (nb > 8) u_sfesi_host.xfer(op, nb - 8, rx);
    u_sfesi_host.frame_close();
  endtask
  // Header of 32 bits then nr bytes read; quiet expects no output
  task automatic id_read(input logic [7:0] op, input logic [7:0] a0, input int nr, input logic [23:0] exp,
                         input logic quiet);
    u_sfesi_host.frame_open();
    u_sfesi_host.xfer(op, 8, rx);
    u_sfesi_host.xfer(8'h00, 8, rx);
    u_sfesi_host.xfer(8'h00, 8, rx);
    u_sfesi_host.xfer(a0, 8, rx);
    for (int k = 0; k < nr; k++) begin
      u_sfesi_host.xfer(8'h00, 8, rx);
      if (!quiet) chk("id byte", exp[23-8*k -: 8], rx);
    end
    if (quiet) chk("output enabled", 8'h00, {7'h00, u_sfesi_host.out_seen});
    u_sfesi_host.frame_close();
  endtask
  // Reset state
  task automatic t_reset();
    chk("asleep", 8'h00, {7'h00, asleep});
    chk("out enable", 8'h01, {7'h00, serial_out_en_n});
    chk("busy", 8'h00, {7'h00, busy});
    $display("test reset done");
  endtask
  // Erase refused: no latch, protected, wrong framing
  task automatic t_refuse();
    op_frame(`SFESI_OP_ERASE, 8);
    chk("busy no latch", 8'h00, {7'h00, busy});
    set_wel();
    for (int p = 1; p < 8; p++) begin
      protect_range_bits = 3'(p);
      op_frame(`SFESI_OP_ERASE, 8);
      chk("busy protected", 8'h00, {7'h00, busy});
    end
    protect_range_bits = 3'h0;
    op_frame(`SFESI_OP_ERASE, 9);
    chk("busy nine bits", 8'h00, {7'h00, busy});
    chk("array kept", 8'h00, rd_data);
    $display("test refuse done");
  endtask
  // Accepted erase, timing and latch clear
  task automatic t_erase();
    int n;
    op_frame(`SFESI_OP_ERASE, 8);
    chk("busy start", 8'h01, {7'h00, busy});
    u_sfesi_host.wait_n(ERASE_CYC - 8);
    chk("busy mid", 8'h01, {7'h00, busy});
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      u_sfesi_host.wait_n(1);
      n++;
    end
    chk("busy end", 8'h00, {7'h00, busy});
    u_sfesi_host.wait_n(2);
    chk("latch clears", 8'h01, n_clear[7:0]);
    chk("latch flag", 8'h00, {7'h00, write_latch_flag});
    for (int a = 0; a < `SFESI_ARRAY_DEPTH; a++) begin
      rd_addr = 6'(a);
      u_sfesi_host.wait_n(1);
      chk("erased word", `SFESI_ERASED, rd_data);
    end
    $display("test erase done");
  endtask
  // Identification reads in both orders
  task automatic t_ids();
    id_read(`SFESI_OP_WAKE, 8'h00, 3, {3{`SFESI_DEVICE_ID}}, 1'b0);
    id_read(`SFESI_OP_MFID, 8'h00, 3, {`SFESI_MAKER_ID, `SFESI_DEVICE_ID, `SFESI_MAKER_ID}, 1'b0);
    id_read(`SFESI_OP_MFID, 8'h01, 3, {`SFESI_DEVICE_ID, `SFESI_MAKER_ID, `SFESI_DEVICE_ID}, 1'b0);
    $display("test ids done");
  endtask
  // Sleep, ignored commands, both wake paths
  task automatic t_sleep();
    op_frame(`SFESI_OP_SLEEP, 8);
    u_sfesi_host.wait_n(610);
    chk("asleep", 8'h01, {7'h00, asleep});
    id_read(`SFESI_OP_MFID, 8'h00, 1, 24'h0, 1'b1);
    ext_busy = 1'b1;
    op_frame(`SFESI_OP_WAKE, 8);
    u_sfesi_host.wait_n(610);
    chk("wake while busy", 8'h01, {7'h00, asleep});
    ext_busy = 1'b0;
    op_frame(`SFESI_OP_WAKE, 8);
    u_sfesi_host.wait_n(300);
    chk("early wake", 8'h01, {7'h00, asleep});
    u_sfesi_host.wait_n(310);
    chk("awake", 8'h00, {7'h00, asleep});
    op_frame(`SFESI_OP_SLEEP, 8);
    u_sfesi_host.wait_n(610);
    id_read(`SFESI_OP_WAKE, 8'h00, 1, {`SFESI_DEVICE_ID, 16'h0}, 1'b0);
    u_sfesi_host.wait_n(200);
    chk("id wake early", 8'h01, {7'h00, asleep});
    u_sfesi_host.wait_n(180);
    chk("id wake done", 8'h00, {7'h00, asleep});
    $display("test sleep done");
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    ext_busy = 1'b0;
    wren = 1'b0;
    protect_range_bits = 3'h0;
    rd_addr = 6'h00;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    u_sfesi_host.wait_n(2);
    t_reset();
    t_refuse();
    t_erase();
    t_ids();
    t_sleep();
    end_sim();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire

// file: sfesi_cfg.svh
// Constants for the serial flash erase, sleep and identification block
//-----------------------------------------------------------------------------
// Overview of operation
// - Whole-array erase sets every location to ones
// - Erase accepted only with write latch set
// - Select must rise right after eighth bit
// - Self-timed erase keeps busy high until done
// - Erase completion clears the write latch
// - Any protected range blocks whole-array erase
// - Framed sleep opcode enters sleep after delay
// - Asleep, only the wake instruction is recognised
// - Power-up always leaves device awake
// - Wake-only: select high for wake time
// - Wake opcode, three dummies, identification out
// - Identification byte repeats until select rises
// - Wake with identification needs shorter delay
// - Wake instruction ignored while busy
// - Combined read: address zero, maker first
// - Address one gives device code first
// - Maker and device codes alternate continuously
// - Bits sampled on rising clock, MSB first
//-----------------------------------------------------------------------------
`ifndef SFESI_CFG_SVH
`define SFESI_CFG_SVH

// Opcodes
`define SFESI_OP_ERASE 8'hc7
`define SFESI_OP_SLEEP 8'hb9
`define SFESI_OP_WAKE 8'hab
`define SFESI_OP_MFID 8'h90
// Erased byte value
`define SFESI_ERASED 8'hff
// Clock period in picoseconds
`define SFESI_CLK_PS 5000
// Times in nanoseconds
`define SFESI_ERASE_NS 2000000
`define SFESI_SLEEP_NS 3000
`define SFESI_WAKE_NS 3000
`define SFESI_WAKE_ID_NS 1800
// Cycle counts (all times round down, no minimum of one)
`define SFESI_ERASE_CYC ((`SFESI_ERASE_NS * 1000) / `SFESI_CLK_PS)
`define SFESI_SLEEP_CYC ((`SFESI_SLEEP_NS * 1000) / `SFESI_CLK_PS)
`define SFESI_WAKE_CYC ((`SFESI_WAKE_NS * 1000) / `SFESI_CLK_PS)
`define SFESI_WAKE_ID_CYC ((`SFESI_WAKE_ID_NS * 1000) / `SFESI_CLK_PS)
// Bits of opcode, dummy and address phases
`define SFESI_OP_BITS 6'd8
`define SFESI_WAKE_HDR_BITS 6'd32
`define SFESI_MFID_HDR_BITS 6'd32
// Array geometry
`define SFESI_ARRAY_DEPTH 64
`define SFESI_ADDR_W 6
// Identity codes (arbitrary values)
`define SFESI_MAKER_ID 8'h5a
`define SFESI_DEVICE_ID 8'h3c

`endif

// file: sfesi_core.sv
// Erase, sleep, wake and identification instruction handling
`timescale 1ns/1ps
`default_nettype none
`include "sfesi_cfg.svh"

module sfesi_core
  import sfesi_pkg::*;
#(
  parameter int ERASE_CYC = `SFESI_ERASE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial pins
  input wire sfesi_spi_s spi,
  output logic serial_out,
  output logic serial_out_en_n,
  // Status from and to rest of device
  input wire logic ext_busy,
  input wire logic write_latch_flag,
  input wire logic [2:0] protect_range_bits,
  output logic busy,
  output logic latch_clear,
  output logic asleep,
  // Array read port
  input wire logic [`SFESI_ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data
);

  //---------------------------------------------------------------------------
  // Declarations
  //---------------------------------------------------------------------------
  localparam int SLEEP_CYC = `SFESI_SLEEP_CYC; // Sleep entry delay
  localparam int WAKE_CYC = `SFESI_WAKE_CYC; // Wake delay
  localparam int WAKE_ID_CYC = `SFESI_WAKE_ID_CYC; // Wake-with-id delay

  logic sclk_q; // Previous clock level
  logic sel_q; // Previous select level
  logic rise; // Clock rising edge
  logic fall; // Clock falling edge
  logic sel_fall; // Frame start
  logic sel_rise; // Frame end
  sfesi_state_e state; // Instruction state
  logic [5:0] bit_cnt; // Bits taken in frame
  logic [7:0] opcode; // Opcode shift register
  logic [23:0] addr; // Address shift register
  logic [7:0] out_byte; // Byte being shifted out
  logic [2:0] out_bit; // Bit index within byte
  logic alt_sel; // Which code follows
  logic erasing; // Erase in progress
  logic [31:0] erase_cnt; // Erase timer
  logic [31:0] pm_cnt; // Sleep or wake timer
  logic pm_pend; // Sleep or wake pending
  logic pm_to_sleep; // Pending goes to sleep
  logic [7:0] array_mem [`SFESI_ARRAY_DEPTH]; // Memory array
  logic [7:0] next_opcode; // Opcode with new bit

  // Codes for the combined read, by order bit
  function automatic logic [7:0] code_of(input logic dev);
    code_of = dev ? `SFESI_DEVICE_ID : `SFESI_MAKER_ID;
  endfunction

  assign rise = spi.sclk & ~sclk_q;
  assign fall = ~spi.sclk & sclk_q;
  assign sel_fall = ~spi.sel_n & sel_q;
  assign sel_rise = spi.sel_n & ~sel_q;
  assign next_opcode = {opcode[6:0], spi.serial_in};
  assign busy = erasing | ext_busy;
  assign rd_data = array_mem[rd_addr];

  //---------------------------------------------------------------------------
  // Edge history
  //---------------------------------------------------------------------------
  // Pin levels of last cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclk_q <= 1'b0;
      sel_q <= 1'b1;
    end else begin
      sclk_q <= spi.sclk;
      sel_q <= spi.sel_n;
    end
  end

  //---------------------------------------------------------------------------
  // Instruction decode
  //---------------------------------------------------------------------------
  // Opcode, header and shift phases
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= SFESI_IDLE;
      bit_cnt <= 6'h00;
      opcode <= 8'h00;
      addr <= 24'h000000;
    end else if (spi.sel_n) begin
      state <= SFESI_IDLE;
    end else if (sel_fall) begin
      state <= SFESI_OPCODE;
      bit_cnt <= 6'h00;
    end else if (rise) begin
      bit_cnt <= bit_cnt + 6'h01;
      case (state)
        SFESI_OPCODE: begin
          opcode <= next_opcode;
          if (bit_cnt == `SFESI_OP_BITS) begin
            // Ninth bit spoils erase or sleep frame
            state <= SFESI_IGNORE;
          end else if (bit_cnt == `SFESI_OP_BITS - 6'h01) begin
            if (asleep && next_opcode != `SFESI_OP_WAKE) begin
              state <= SFESI_IGNORE;
            end else if (next_opcode == `SFESI_OP_WAKE && busy) begin
              state <= SFESI_IGNORE;
            end else if (next_opcode == `SFESI_OP_WAKE || next_opcode == `SFESI_OP_MFID) begin
              state <= SFESI_HEADER;
            end else if (next_opcode == `SFESI_OP_ERASE || next_opcode == `SFESI_OP_SLEEP) begin
              state <= SFESI_OPCODE;
            end else begin
              state <= SFESI_IGNORE;
            end
          end
        end
        SFESI_HEADER: begin
          addr <= {addr[22:0], spi.serial_in};
          if (bit_cnt == `SFESI_WAKE_HDR_BITS - 6'h01) begin
            state <= SFESI_SHIFT;
          end
        end
        SFESI_SHIFT: begin
          state <= SFESI_SHIFT;
        end
        SFESI_IGNORE: begin
          state <= SFESI_IGNORE;
        end
        default: begin
          state <= SFESI_IDLE;
        end
      endcase
    end
  end

  //---------------------------------------------------------------------------
  // Identification output
  //---------------------------------------------------------------------------
  // Load at header end, shift on falling edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_byte <= 8'h00;
      out_bit <= 3'h7;
      alt_sel <= 1'b0;
      serial_out <= 1'b0;
      serial_out_en_n <= 1'b1;
    end else if (spi.sel_n) begin
      serial_out_en_n <= 1'b1;
      out_bit <= 3'h7;
    end else if (state == SFESI_HEADER && rise && bit_cnt == `SFESI_MFID_HDR_BITS - 6'h01) begin
      if (opcode == `SFESI_OP_WAKE) begin
        out_byte <= `SFESI_DEVICE_ID;
      end else begin
        // Address bit zero picks first code
        out_byte <= code_of(spi.serial_in);
        alt_sel <= ~spi.serial_in;
      end
      out_bit <= 3'h7;
    end else if (state == SFESI_SHIFT && fall) begin
      // Drive only in output phase, MSB first
      serial_out_en_n <= 1'b0;
      serial_out <= out_byte[out_bit];
      out_bit <= out_bit - 3'h1;
      if (out_bit == 3'h0) begin
        if (opcode == `SFESI_OP_MFID) begin
          out_byte <= code_of(alt_sel);
          alt_sel <= ~alt_sel;
        end else begin
          out_byte <= `SFESI_DEVICE_ID;
        end
      end
    end
  end

  //---------------------------------------------------------------------------
  // Whole-array erase
  //---------------------------------------------------------------------------
  // Self-timed erase cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      erasing <= 1'b0;
      erase_cnt <= 32'h00000000;
      latch_clear <= 1'b0;
    end else begin
      latch_clear <= 1'b0;
      if (erasing) begin
        if (erase_cnt >= 32'(ERASE_CYC - 1)) begin
          erasing <= 1'b0;
          latch_clear <= 1'b1;
        end else begin
          erase_cnt <= erase_cnt + 32'h1;
        end
      // Select rises right after eighth bit
      end else if (sel_rise && state == SFESI_OPCODE && bit_cnt == `SFESI_OP_BITS && opcode == `SFESI_OP_ERASE
                   && !asleep && !busy
                   && write_latch_flag && protect_range_bits == 3'h0) begin
        erasing <= 1'b1;
        erase_cnt <= 32'h00000000;
      end
    end
  end

  // Array storage, set to all ones in first erase cycle
  generate
    for (genvar i = 0; i < `SFESI_ARRAY_DEPTH; i++) begin : g_cell
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          array_mem[i] <= 8'h00;
        end else if (erasing && erase_cnt == 32'h0) begin
          array_mem[i] <= `SFESI_ERASED;
        end
      end
    end
  endgenerate

  //---------------------------------------------------------------------------
  // Sleep and wake
  //---------------------------------------------------------------------------
  // Sleep state and its delays
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      asleep <= 1'b0;
      pm_pend <= 1'b0;
      pm_to_sleep <= 1'b0;
      pm_cnt <= 32'h00000000;
    end else if (pm_pend) begin
      if (!spi.sel_n && !pm_to_sleep) begin
        pm_pend <= 1'b0;
      end else if (pm_cnt == 32'h0) begin
        pm_pend <= 1'b0;
        asleep <= pm_to_sleep;
      end else begin
        pm_cnt <= pm_cnt - 32'h1;
      end
    end else if (sel_rise && state == SFESI_OPCODE && bit_cnt == `SFESI_OP_BITS
                 && opcode == `SFESI_OP_SLEEP && !asleep) begin
      pm_pend <= 1'b1;
      pm_to_sleep <= 1'b1;
      pm_cnt <= 32'(SLEEP_CYC - 1);
    end else if (sel_rise && asleep && opcode == `SFESI_OP_WAKE && state != SFESI_IGNORE
                 && (state == SFESI_SHIFT || bit_cnt == `SFESI_OP_BITS)) begin
      pm_pend <= 1'b1;
      pm_to_sleep <= 1'b0;
      pm_cnt <= (state == SFESI_SHIFT) ? 32'(WAKE_ID_CYC - 1) : 32'(WAKE_CYC - 1);
    end
  end

  //---------------------------------------------------------------------------
  // Assertions
  //---------------------------------------------------------------------------
  sequence erase_start_s;
    !erasing ##1 erasing;
  endsequence

  erase_latch_a: assert property (@(posedge sys_clk) disable iff (rst)
    erase_start_s |-> $past(write_latch_flag, 1)) else $error("erase without write latch");
  erase_prot_a: assert property (@(posedge sys_clk) disable iff (rst)
    erase_start_s |-> $past(protect_range_bits, 1) == 3'h0) else $error("erase while protected");
  erase_frame_a: assert property (@(posedge sys_clk) disable iff (rst)
    erase_start_s |-> $past(sel_rise, 1) && $past(bit_cnt, 1) == `SFESI_OP_BITS) else $error("erase misframed");
  erase_busy_a: assert property (@(posedge sys_clk) disable iff (rst)
    erasing && erase_cnt < 32'(ERASE_CYC - 1) |=> busy && erasing) else $error("busy low during erase");
  erase_end_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(erasing) |-> latch_clear) else $error("latch not cleared");
  erase_fill_a: assert property (@(posedge sys_clk) disable iff (rst)
    erase_start_s ##1 1'b1 |-> array_mem[rd_addr] == `SFESI_ERASED) else $error("array not erased");
  sleep_ign_a: assert property (@(posedge sys_clk) disable iff (rst)
    asleep && state == SFESI_OPCODE && rise && bit_cnt == 6'h07 && next_opcode != `SFESI_OP_WAKE
    |=> state != SFESI_HEADER) else $error("instruction taken asleep");
  // Wake refused while a cycle runs
  wake_busy_a: assert property (@(posedge sys_clk) disable iff (rst)
    state == SFESI_OPCODE && rise && bit_cnt == 6'h07 && next_opcode == `SFESI_OP_WAKE && busy
    |=> state == SFESI_IGNORE) else $error("wake taken while busy");
  // A ninth opcode bit ends the frame's use
  ninth_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    state == SFESI_OPCODE && rise && bit_cnt == `SFESI_OP_BITS && !spi.sel_n && !sel_fall
    |=> state == SFESI_IGNORE || spi.sel_n) else $error("ninth bit accepted");
  out_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    !serial_out_en_n |-> state == SFESI_SHIFT || $past(state, 1) == SFESI_SHIFT) else $error("drive outside output");

endmodule
`default_nettype wire

// file: sfesi_host.sv
// Host controller model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module sfesi_host
  import sfesi_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Serial pins
  output sfesi_spi_s spi,
  input wire logic serial_out,
  input wire logic serial_out_en_n
);
  // Set when the device drove its output in this frame
  logic out_seen;
  // Idle: deselected, clock parked low
  initial begin
    spi = '{sel_n: 1'b1, sclk: 1'b0, serial_in: 1'b0};
  end
  // Watch output enable inside frames, clear between frames
  always @(posedge sys_clk) begin
    if (spi.sel_n) begin
      out_seen <= 1'b0;
    end else if (serial_out_en_n === 1'b0) begin
      out_seen <= 1'b1;
    end
  end
  // Wait falling system clock edges
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Select low with the clock idle
  task automatic frame_open();
    spi.sel_n = 1'b0;
    wait_n(4);
  endtask
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      spi.sclk = 1'b0;
      spi.serial_in = tx[7-i];
      wait_n(4);
      spi.sclk = 1'b1;
      rx = {rx[6:0], serial_out};
      wait_n(4);
    end
  endtask
  task automatic frame_close();
    spi.sclk = 1'b0;
    wait_n(4);
    spi.sel_n = 1'b1;
    spi.serial_in = ~spi.serial_in;
    wait_n(4);
  endtask
endmodule
`default_nettype wire

// file: sfesi_pkg.sv
// Types for the serial flash erase, sleep and identification block
package sfesi_pkg;
  // Serial pins from the host
  typedef struct packed {
    logic sel_n;
    logic sclk;
    logic serial_in;
  } sfesi_spi_s;
  // Shared status bits
  typedef struct packed {
    logic busy;
    logic write_latch_flag;
    logic [2:0] protect_range_bits;
  } sfesi_status_s;
  // Instruction state
  typedef enum logic [2:0] {
    SFESI_IDLE = 3'b000,
    SFESI_OPCODE = 3'b001,
    SFESI_HEADER = 3'b010,
    SFESI_SHIFT = 3'b011,
    SFESI_IGNORE = 3'b100
  } sfesi_state_e;
endpackage
